// ---- design/devt_consts.vh ----
// register offsets, field positions and reset values for the event/irq status block
// assumes inclusion by bare name from design files; definitions only
`ifndef DEVT_CONSTS_VH
`define DEVT_CONSTS_VH
`define DEVT_OFF_IRQ_ENABLE    12'h020
`define DEVT_OFF_RAW_STATUS    12'h024
`define DEVT_OFF_MASKED_STATUS 12'h028
`define DEVT_OFF_IRQ_CLEAR     12'h02c
`define DEVT_OFF_MGR_FAULT     12'h030
`define DEVT_OFF_INT_STATUS    12'h040
`define DEVT_OFF_INT_CLEAR     12'h044
`define DEVT_OFF_INT_ENABLE    12'h048
`define DEVT_ADDR_W            12
`define DEVT_FAULT_BIT         0
`define DEVT_RST_ENABLE        32'h0000_0000
`define DEVT_RST_STATUS        32'h0000_0000
`define DEVT_EVT_FAULT         0
`define DEVT_EVT_SEV_IRQ       1
`define DEVT_EVT_SEV_EVENT     2
`define DEVT_EVT_WFE_HIT       3
`define DEVT_NUM_EVT           4
`define DEVT_RESP_OKAY         2'b00
`define DEVT_RESP_SLVERR       2'b10
`endif

// ---- design/devt_event_irq.v ----
// event-interrupt resources: raw/masked status, irq lines, clear, manager fault flag
// assumes one clock, AXI4-Lite master on the register side, instruction engine
// delivering one-cycle send/wait pulses with a 5-bit resource number
//
// What this block does
// R01 - raw status bit per resource: 1 while event pending or its irq high
// R02 - send-event uses the enable bit to pick irq line or broadcast event
// R03 - event-mode bit cleared when a thread's wait-for-event consumes it
// R04 - irq-mode bit cleared by writing its bit of the clear register
// R05 - masked status bit is 1 exactly when interrupt line N is high
// R06 - masked status bit held 0 while resource is in event mode
// R07 - software drops an interrupt through the clear register or by writing its enable bit to 0
// R08 - manager fault flag in bit 0, 1 while manager is Faulting
// R09 - enable 1 raises irq line N; enable 0 signals event N to all threads
// R10 - clear register write-only; writing 1 clears, writing 0 does nothing
//
// register map, byte addresses on the 12-bit register bus:
//   0x020 irq_enable_reg       read/write, strobes honoured per byte
//   0x024 event_irq_raw_status read only
//   0x028 irq_masked_status    read only, mirrors the irq lines
//   0x02c irq_clear            write only, reads as zero
//   0x030 manager_fault_status read only, only bit 0 carries meaning
//   0x040 block irq status     read only, bits 3:0
//   0x044 block irq clear      write only, bits 3:0, set beats clear
//   0x048 block irq enable     read/write, bits 3:0
//
// block irq status bits:
//   0 manager thread entered the faulting state
//   1 send-event hit a resource in irq mode
//   2 send-event hit a resource in event mode
//   3 a wait-for-event consumed a pending event
//
// timing:
//   a send or wait pulse is taken on the edge where its valid is high;
//   raw status, irq lines and pending events show the result one cycle on.
//   a register write takes effect on the edge where bvalid rises, and the
//   irq lines follow a mode change on that very edge, so the masked status
//   read back and the lines never disagree.
//   a read returns the value sampled on the edge that takes the address.
//
// hazards and limits:
//   a send and a clear (or wait) on the same resource in one cycle leave
//   the bit set: losing a fresh event is worse than a spurious interrupt.
//   irq_clear only touches irq-mode bits; event-mode bits need a wait.
//   a wait on an irq-mode resource is ignored and does not pulse done.
//   writes to read-only or unmapped offsets answer with an error and
//   change nothing; unmapped reads answer with an error and zero data.
//   the fault flag is registered, so it lags the manager state by a cycle.
//
// bus handshake:
//   ready signals drop for at least one cycle after each handshake, which
//   keeps the slave simple at the cost of peak bus throughput: one read per 3 cycles, one write per 4.
//   only one write and one read are in flight at a time.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "devt_consts.vh"

module devt_event_irq #(
  parameter NUM_RES = 32
) (
  input  wire        CORE_CLK,
  input  wire        RST_N,
  input  wire        SEV_VALID,
  input  wire [4:0]  SEV_NUM,
  input  wire        WFE_VALID,
  input  wire [4:0]  WFE_NUM,
  input  wire        MGR_FAULTING,
  output reg  [31:0] IRQ,
  output reg  [31:0] EVENT_PENDING,
  output reg         WFE_DONE,
  output reg         BLOCK_IRQ,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  reg  [31:0] enable_q;        // irq_enable_reg: 1 = irq, 0 = event
  reg  [31:0] enable_d;
  reg  [31:0] raw_q;
  reg  [31:0] raw_d;
  reg         fault_q;
  reg  [3:0]  ist_q;           // block interrupt status
  reg  [3:0]  ist_d;
  reg  [3:0]  ien_q;
  reg  [11:0] aw_q;
  reg  [31:0] w_q;
  reg  [3:0]  ws_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [31:0] rd_d;
  reg         rd_ok;
  wire [31:0] sev_dec;
  wire [31:0] wfe_dec;
  wire [31:0] line_clear_bits;
  wire [31:0] masked;
  wire [31:0] wmask;
  wire        wr_fire;
  wire        wr_hit;
  wire [3:0]  evt;

  assign sev_dec = SEV_VALID ? (32'h0000_0001 << SEV_NUM) : 32'h0000_0000;
  assign wfe_dec = WFE_VALID ? (32'h0000_0001 << WFE_NUM) : 32'h0000_0000;
  assign wmask   = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;

  // write-only clear: ones drop the line, zeros are ignored
  assign line_clear_bits = (wr_fire && aw_q == `DEVT_OFF_IRQ_CLEAR) ?
                           (w_q & wmask & enable_q) : 32'h0000_0000; // see R10 see R04 see R07
  // only irq-mode bits can show here
  assign masked = raw_q & enable_q; // see R05 see R06

  // raw status: send sets, wfe or clear drops; a fresh send wins over a clear
  always @*
  begin
    raw_d = raw_q;
    raw_d = raw_d & ~line_clear_bits; // see R04
    raw_d = raw_d & ~(wfe_dec & ~enable_q); // see R03
    raw_d = raw_d | sev_dec; // see R01 see R02
  end

  // next mode bits; lines use these so a mode change moves the bit at once
  always @*
  begin
    enable_d = enable_q;
    if (wr_fire && aw_q == `DEVT_OFF_IRQ_ENABLE)
    begin
      enable_d = (enable_q & ~wmask) | (w_q & wmask); // see R02
    end
  end

  assign evt[`DEVT_EVT_FAULT]     = MGR_FAULTING & ~fault_q;
  assign evt[`DEVT_EVT_SEV_IRQ]   = |(sev_dec & enable_q);
  assign evt[`DEVT_EVT_SEV_EVENT] = |(sev_dec & ~enable_q);
  assign evt[`DEVT_EVT_WFE_HIT]   = |(wfe_dec & raw_q & ~enable_q);
  assign wr_hit = wr_fire && aw_q == `DEVT_OFF_INT_CLEAR;

  // sticky block status; set beats a same-cycle clear
  always @*
  begin
    ist_d = ist_q;
    if (wr_hit)
    begin
      ist_d = ist_d & ~w_q[3:0];
    end
    ist_d = ist_d | evt;
  end

  // state registers
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      raw_q         <= `DEVT_RST_STATUS;
      enable_q      <= `DEVT_RST_ENABLE;
      fault_q       <= 1'b0;
      ist_q         <= 4'h0;
      ien_q         <= 4'h0;
      IRQ           <= 32'h0000_0000;
      EVENT_PENDING <= 32'h0000_0000;
      WFE_DONE      <= 1'b0;
      BLOCK_IRQ     <= 1'b0;
    end
    else
    begin
      raw_q         <= raw_d;
      fault_q       <= MGR_FAULTING; // see R08
      ist_q         <= ist_d;
      enable_q      <= enable_d; // see R02
      IRQ           <= raw_d & enable_d; // see R09 see R05
      EVENT_PENDING <= raw_d & ~enable_d; // see R09
      WFE_DONE      <= |(wfe_dec & raw_q & ~enable_q); // see R03
      BLOCK_IRQ     <= |(ist_d & ien_q);
      if (wr_fire && aw_q == `DEVT_OFF_INT_ENABLE)
      begin
        ien_q <= w_q[3:0];
      end
    end
  end

  // write channel: address and data taken in either order, response after both
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_q          <= 12'h000;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `DEVT_RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_have_q && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_q      <= S_AXI_AWADDR;
        aw_have_q <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_q      <= S_AXI_WDATA;
        ws_q     <= S_AXI_WSTRB;
        w_have_q <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        S_AXI_BVALID <= 1'b1;
        // read-only or unknown offsets answer with an error
        S_AXI_BRESP  <= (aw_q == `DEVT_OFF_IRQ_ENABLE || aw_q == `DEVT_OFF_IRQ_CLEAR ||
                         aw_q == `DEVT_OFF_INT_CLEAR || aw_q == `DEVT_OFF_INT_ENABLE) ?
                        `DEVT_RESP_OKAY : `DEVT_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
    end
  end

  // read decode; clear registers are write-only and read as zero
  always @*
  begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `DEVT_OFF_IRQ_ENABLE:    rd_d = enable_q;
      `DEVT_OFF_RAW_STATUS:    rd_d = raw_q; // see R01
      `DEVT_OFF_MASKED_STATUS: rd_d = masked; // see R05
      `DEVT_OFF_IRQ_CLEAR:     rd_d = 32'h0000_0000; // see R10
      `DEVT_OFF_MGR_FAULT:     rd_d[`DEVT_FAULT_BIT] = fault_q; // see R08
      `DEVT_OFF_INT_STATUS:    rd_d[3:0] = ist_q;
      `DEVT_OFF_INT_CLEAR:     rd_d = 32'h0000_0000;
      `DEVT_OFF_INT_ENABLE:    rd_d[3:0] = ien_q;
      default:                 rd_ok = 1'b0;
    endcase
  end

  // read channel: one outstanding read, answered the cycle after acceptance
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `DEVT_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_d;
        S_AXI_RRESP   <= rd_ok ? `DEVT_RESP_OKAY : `DEVT_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule // devt_event_irq
`default_nettype wire

// ---- tb/devt_event_irq_chk.sv ----
// checker: line, wait and write-answer properties of devt_event_irq
// assumes bind onto the block, seeing its ports only
`timescale 1ns/1ns
`default_nettype none
module devt_event_irq_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        SEV_VALID,
  input wire logic [4:0]  SEV_NUM,
  input wire logic        WFE_VALID,
  input wire logic [4:0]  WFE_NUM,
  input wire logic [31:0] IRQ,
  input wire logic [31:0] EVENT_PENDING,
  input wire logic        WFE_DONE,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // a wait finding its event pending, not refreshed by a send on that edge
  sequence s_hit; WFE_VALID && EVENT_PENDING[WFE_NUM] && !(SEV_VALID && SEV_NUM == WFE_NUM);
  endsequence
  sequence s_wr_done; $rose(S_AXI_BVALID); endsequence
  property p_mode; (IRQ & EVENT_PENDING) == 32'h0; endproperty
  a_mode: assert property (p_mode) else $error("both modes");
  property p_sev; SEV_VALID |=> IRQ[$past(SEV_NUM)] || EVENT_PENDING[$past(SEV_NUM)]; endproperty
  a_sev: assert property (p_sev) else $error("send lost");
  property p_hit; s_hit |=> WFE_DONE && !EVENT_PENDING[$past(WFE_NUM)]; endproperty
  a_hit: assert property (p_hit) else $error("wait hit");
  property p_miss; WFE_VALID && !EVENT_PENDING[WFE_NUM] |=> !WFE_DONE; endproperty
  a_miss: assert property (p_miss) else $error("wait miss");
  property p_done; WFE_DONE |-> $past(WFE_VALID); endproperty
  a_done: assert property (p_done) else $error("stray done");
  property p_rise; |(IRQ & ~$past(IRQ)) |-> $past(SEV_VALID) || $rose(S_AXI_BVALID); endproperty
  a_rise: assert property (p_rise) else $error("irq rise");
  property p_fall; |($past(IRQ) & ~IRQ) |-> s_wr_done; endproperty
  a_fall: assert property (p_fall) else $error("irq fall");
  property p_bans; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bans: assert property (p_bans) else $error("write answer");
endmodule // devt_event_irq_chk
bind devt_event_irq devt_event_irq_chk devt_event_irq_chk_inst (.*);
`default_nettype wire

// ---- tb/devt_event_irq_tb.sv ----
// bench: instruction pulses, fault level and AXI4-Lite register traffic
// assumes devt_event_irq with its checker bound
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,s) begin compares++; if ((e) !== (s)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module devt_event_irq_tb;
  logic        CORE_CLK = 0, RST_N = 0, SEV_VALID = 0, WFE_VALID = 0, MGR_FAULTING = 0;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
  logic        S_AXI_BREADY = 1, S_AXI_RREADY = 1; // answers are always taken at once
  logic [4:0]  SEV_NUM = 0, WFE_NUM = 0, n;
  logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, IRQ, EVENT_PENDING, S_AXI_RDATA, m, r = 0, rs = 32'h34b6fb2f;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        WFE_DONE, BLOCK_IRQ, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID;
  logic [33:0] exp_q[$], ex;
  int          error_cnt = 0, compares = 0;
  devt_event_irq devt_event_irq_inst (.*);
  // free-running core clock
  initial forever #10 CORE_CLK = ~CORE_CLK;
  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    error_cnt++;
    test_done;
  end
  // read answers are matched in issue order against the notes rd left
  always @(posedge CORE_CLK)
    if (S_AXI_RVALID)
    begin
      ex = exp_q.pop_front();
      `CHK("read", ex, {S_AXI_RRESP, S_AXI_RDATA})
    end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // one strobe pulse, then a quiet edge so pulses never merge
  task ev(input logic w, input logic [4:0] k);
    {WFE_VALID, SEV_VALID} <= w ? 2'b10 : 2'b01;
    SEV_NUM <= k;
    WFE_NUM <= k;
    @(posedge CORE_CLK);
    {WFE_VALID, SEV_VALID} <= 2'b00;
    @(posedge CORE_CLK);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID} <= 2'b11;
    do
    begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    `CHK("bresp", (a == 12'h024) ? 2'b10 : 2'b00, S_AXI_BRESP)
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
  endtask
  task test_done;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence; bit 0 forced to irq mode and bit 1 to event mode
  initial
  begin
    int i;
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    rd(12'h024, 34'h0);
    rd(12'h3fc, {2'b10, 32'h0});
    wr(12'h024, 32'hffff_ffff);
    rd(12'h024, 34'h0);
    m = (xs(rs) & ~32'h2) | 32'h1;
    wr(12'h020, m);
    wr(12'h048, 32'h8);
    for (i = 0; i < 4; i++)
    begin
      rs = xs(rs);
      n = (i < 2) ? i[4:0] : rs[4:0];
      ev(1'b0, n);
      r[n] = 1'b1;
    end
    rd(12'h024, {2'b0, r});
    rd(12'h028, {2'b0, r & m});
    `CHK("masked", 1'b0, BLOCK_IRQ)
    wr(12'h02c, 32'hffff_ffff);
    r = r & ~m;
    rd(12'h024, {2'b0, r});
    rd(12'h02c, 34'h0);
    for (i = 0; i < 32; i++)
      if (r[i]) ev(1'b1, i[4:0]);
    ev(1'b1, 5'h0);
    rd(12'h024, 34'h0);
    `CHK("blk_irq", 1'b1, BLOCK_IRQ)
    MGR_FAULTING <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    rd(12'h030, 34'h1);
    rd(12'h040, 34'hf);
    MGR_FAULTING <= 1'b0;
    wr(12'h044, 32'hf);
    rd(12'h040, 34'h0);
    rd(12'h030, 34'h0);
    `CHK("cleared", 1'b0, BLOCK_IRQ)
    test_done;
  end
endmodule // devt_event_irq_tb
`default_nettype wire
